// >>> pkg/overlay_regs.svh
// Register offsets, field positions and reset values of the overlay register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef OVERLAY_REGS_SVH
`define OVERLAY_REGS_SVH

// I/O byte addresses of each register word
`define OVL_CTRL_ADDR        16'ha3d0
`define OVL_COLOR_LO_ADDR    16'ha7d0
`define OVL_COLOR_HI_ADDR    16'habd0
`define OVL_POS_ADDR         16'hafd0
`define OVL_BASE_ADDR        16'hb3d0

// Control register fields
`define CTRL_SEL_LSB         0
`define CTRL_CORNER_BIT      5
`define CTRL_MENU_WIDTH_BIT  8
`define CTRL_XZOOM_BIT       9
`define CTRL_YZOOM_BIT       10
`define CTRL_AUTOZOOM_BIT    11
`define CTRL_TRANSP_BIT      12
`define CTRL_RSVD13_BIT      13
`define CTRL_POSCTL_BIT      14
`define CTRL_BLINK_BIT       15
// Writable bits: 15..0 except 13; 4..2 are read/write reserved
`define CTRL_WMASK           32'h0000dfff

// Position register fields
`define POS_X_MAG_MSB        10
`define POS_X_SIGN_BIT       15
`define POS_Y_MAG_LSB        16
`define POS_Y_MAG_MSB        26
`define POS_Y_SIGN_BIT       31
`define POS_WMASK            32'h87ff87ff

// Base address field 20..10
`define BASE_LSB             10
`define BASE_MSB             20
`define BASE_WMASK           32'h001ffc00

// Colour field layout inside a 16-bit half
`define COL_BLUE_MSB         4
`define COL_GREEN_LSB        5
`define COL_GREEN_MSB        10
`define COL_RED_LSB          11

`define REG_RESET            32'h00000000

`endif

// >>> pkg/overlay_pkg.sv
// Types shared by the overlay register bank and its helpers.
// Assumes overlay_regs.svh is on the include path.
package overlay_pkg;
  `include "overlay_regs.svh"

  typedef enum logic [1:0] {
    SEL_OFF,
    SEL_CUR32,
    SEL_CUR64,
    SEL_MENU
  } overlay_sel_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_CTRL,
    REG_COLOR_LO,
    REG_COLOR_HI,
    REG_POS,
    REG_BASE
  } reg_sel_t;
endpackage

// >>> hdl/overlay_pos_calc.sv
// Sign-magnitude position to two's complement, with low-resolution halving.
// Assumes the caller supplies register fields already stored.
`timescale 1ns/1ps
`default_nettype none
module overlay_pos_calc
  import overlay_pkg::*;
(
  input  wire logic        sign,
  input  wire logic [10:0] mag,
  input  wire logic        halve,
  output logic      [11:0] pos
);
  wire [11:0] mag_eff;
  wire [11:0] mag_ext;

  // Halve the magnitude before sign so negative positions stay symmetric
  assign mag_ext = {1'b0, mag};
  assign mag_eff = halve ? (mag_ext >> 1) : mag_ext;
  assign pos     = sign ? (12'h000 - mag_eff) : mag_eff;
endmodule
`default_nettype wire

// >>> hdl/overlay_color_pick.sv
// Selects the displayed colour for a 2-bit overlay pixel index.
// Assumes colour index and mode are stable in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module overlay_color_pick
  import overlay_pkg::*;
(
  input  wire logic [63:0] colors,
  input  wire logic [1:0]  index,
  input  wire logic        menu_mode,
  input  wire logic        transp_on,
  output logic      [15:0] color,
  output logic             transparent
);
  wire [1:0] idx_eff;

  // Cursor modes only know entries 0 and 1
  assign idx_eff     = menu_mode ? index : {1'b0, index[0]};
  assign color       = colors[idx_eff*16 +: 16];
  assign transparent = transp_on && (idx_eff == 2'h2);
endmodule
`default_nettype wire

// >>> hdl/overlay_regs_bank.sv
// Overlay register bank: control, colours, position and base address,
// plus the derived display controls handed to the pixel pipeline.
// Assumes a simple synchronous I/O port: address, write/read strobes and
// per-halfword enables; read data returned one cycle after the read strobe.
//
// Functional notes
// - Auto zoom with bits 13,14 clear doubles menu width hi-res, halves menu X lo-res
// - Transparency makes colour 2 transparent only in 64x64 pop-up mode
// - Position control clear halves X in low-res menu mode; set leaves it unchanged
// - Blink enable gates overlay with blink phase; clear shows it steadily
// - Colours are 5-6-5 RGB; second colour sits in upper halfword
// - Colour registers accept 16-bit halves or full 32-bit writes
// - Colour writes reach display output immediately, no frame wait
// - Colours 2 and 3 used only in pop-up menu mode
// - X position: 11-bit magnitude bits 10..0, sign bit 15
// - Y position: 11-bit magnitude bits 26..16, sign bit 31
// - Position is offset from reference corner to image corner
// - Each axis halfword writable alone; unused bits ignored
// - Base address from bits 20..10; bits 9..0 read zero
// - All registers readable and writable by 16- or 32-bit I/O
// - Overlay select takes effect at next vertical blank
// - Corner select picks blanking or display-enable reference
//
// Host port, synchronous to clk
//   io_addr      byte address; low two bits ignored
//   io_wr        write strobe, one cycle per access
//   io_rd        read strobe, one cycle per access
//   io_half_en   bit 0 low halfword, bit 1 high; both for 32-bit
//   io_wdata     write data; disabled halves keep their old value
//   io_rdata     read data; disabled halves read zero
//   io_rvalid    one-cycle pulse alongside the read data
//
// Display-side inputs, taken as synchronous to clk
//   vblank       high in vertical blank; select moves only then
//   low_res      high in low-resolution modes
//   blink_phase  on phase of the external blink timer
//   pix_index    two-bit index read from the overlay image
//
// Display-side outputs, all straight from flops
//   overlay_sel       select in force for this frame
//   overlay_visible   select on and, when blinking, in the on phase
//   reference_corner  corner bit from control
//   menu_two_bpp      menu width bit from control
//   x_zoom, y_zoom    manual zoom bits from control
//   width_double      auto zoom in a high-resolution menu
//   pos_x, pos_y      two's complement offsets, X halved when asked
//   image_base        base field; low ten address bits implied zero
//   pix_color         colour for pix_index, one cycle later
//   pix_transparent   index 2 in the 64x64 menu with transparency on
//
// Register words, low two address bits ignored
//   a3d0  overlay_control
//   a7d0  overlay_color_pair_low
//   abd0  overlay_color_pair_high
//   afd0  overlay_position
//   b3d0  overlay_base_address
//   other addresses read zero and drop writes
//
// overlay_control fields
//   1:0    select: off, 32x32 cursor, 64x64 cursor, pop-up menu
//   4:2    spare, read/write, software keeps them zero
//   5      reference corner: blanking or display enable
//   7:6    spare, read/write
//   8      menu width: 0 is 128 wide at 1 bpp, 1 is 64 wide at 2 bpp
//   9      manual horizontal zoom
//   10     manual vertical zoom
//   11     horizontal auto zoom
//   12     colour 2 transparent in the 64x64 menu
//   13     not stored, reads zero
//   14     position control: 1 stops the low-res halving
//   15     blink enable
//   31:16  not stored, read zero
//
// Colour pair fields, both registers alike
//   15:0   colour zero or two: red 15:11, green 10:5, blue 4:0
//   31:16  colour one or three, same layout
//
// overlay_position fields
//   10:0   horizontal magnitude
//   14:11  not stored, read zero
//   15     horizontal sign
//   26:16  vertical magnitude
//   30:27  not stored, read zero
//   31     vertical sign
//
// overlay_base_address fields
//   9:0    not stored, read zero; image sits on a 1024-byte boundary
//   20:10  image base in display memory
//   31:21  not stored, read zero
//
// Timing, one clock throughout
//   reset: every register and output clears to zero
//   write: register loaded at the edge that samples the strobe
//   read: data and valid registered, standing one cycle after the strobe
//   display outputs: one cycle behind the register or input
//   select: loaded at any edge with vblank high, out one cycle later
//   colours, position, base and zoom: no frame wait
//
// Limitations
//   blink rate and duty live outside; blink_phase only gates visibility
//   a read in the write cycle of the same word returns the old value
//   negative positions in menu mode and base bit 10 in the 128x128 menu
//   are left to software to avoid; the logic does not trap them
//   a 1 bpp menu image supplies only indices 0 and 1
//   zero reset values are a choice; software should program every word
`timescale 1ns/1ps
`default_nettype none
`include "overlay_regs.svh"
module overlay_regs_bank
  import overlay_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [1:0]  io_half_en,
  input  wire logic [31:0] io_wdata,
  output logic      [31:0] io_rdata,
  output logic             io_rvalid,
  input  wire logic        vblank,
  input  wire logic        low_res,
  input  wire logic        blink_phase,
  input  wire logic [1:0]  pix_index,
  output logic      [1:0]  overlay_sel,
  output logic             overlay_visible,
  output logic             reference_corner,
  output logic             menu_two_bpp,
  output logic             x_zoom,
  output logic             y_zoom,
  output logic             width_double,
  output logic      [11:0] pos_x,
  output logic      [11:0] pos_y,
  output logic      [10:0] image_base,
  output logic      [15:0] pix_color,
  output logic             pix_transparent
);
  // Stored register words
  logic [31:0] overlay_control_r;
  logic [31:0] overlay_color_pair_low_r;
  logic [31:0] overlay_color_pair_high_r;
  logic [31:0] overlay_position_r;
  logic [31:0] overlay_base_address_r;
  // Select in force for the current frame
  logic [1:0]  sel_active_r;
  // Read port
  logic [31:0] rdata_r;
  logic        rvalid_r;
  // Output flops
  logic [1:0]  overlay_sel_r;
  logic        visible_r;
  logic        corner_r;
  logic        two_bpp_r;
  logic        x_zoom_r;
  logic        y_zoom_r;
  logic        width_double_r;
  logic [11:0] pos_x_r;
  logic [11:0] pos_y_r;
  logic [10:0] image_base_r;
  logic [15:0] pix_color_r;
  logic        pix_transparent_r;

  // Address decode used by both the write and read paths
  function automatic reg_sel_t decode(input logic [15:0] a);
    reg_sel_t s;
    s = REG_NONE;
    case (a & 16'hfffc)
      `OVL_CTRL_ADDR:     s = REG_CTRL;
      `OVL_COLOR_LO_ADDR: s = REG_COLOR_LO;
      `OVL_COLOR_HI_ADDR: s = REG_COLOR_HI;
      `OVL_POS_ADDR:      s = REG_POS;
      `OVL_BASE_ADDR:     s = REG_BASE;
      default:            s = REG_NONE;
    endcase
    return s;
  endfunction

  // Merge write data per halfword, then mask off bits that do not exist
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [1:0] en, input logic [31:0] wmask);
    logic [31:0] m;
    m = {en[1] ? wd[31:16] : old[31:16], en[0] ? wd[15:0] : old[15:0]};
    return m & wmask;
  endfunction

  wire reg_sel_t    sel_dec = decode(io_addr);
  wire [31:0] ctrl_nxt     = merge(overlay_control_r, io_wdata, io_half_en,
                                   `CTRL_WMASK);
  wire [31:0] col_lo_nxt   = merge(overlay_color_pair_low_r, io_wdata, io_half_en,
                                   32'hffffffff);
  wire [31:0] col_hi_nxt   = merge(overlay_color_pair_high_r, io_wdata, io_half_en,
                                   32'hffffffff);
  wire [31:0] pos_nxt      = merge(overlay_position_r, io_wdata, io_half_en,
                                   `POS_WMASK);
  wire [31:0] base_nxt     = merge(overlay_base_address_r, io_wdata, io_half_en,
                                   `BASE_WMASK);
  wire        wr_ctrl      = io_wr && (sel_dec == REG_CTRL);
  wire        wr_col_lo    = io_wr && (sel_dec == REG_COLOR_LO);
  wire        wr_col_hi    = io_wr && (sel_dec == REG_COLOR_HI);
  wire        wr_pos       = io_wr && (sel_dec == REG_POS);
  wire        wr_base      = io_wr && (sel_dec == REG_BASE);

  // Register writes, 16- or 32-bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overlay_control_r         <= `REG_RESET;
      overlay_color_pair_low_r  <= `REG_RESET;
      overlay_color_pair_high_r <= `REG_RESET;
      overlay_position_r        <= `REG_RESET;
      overlay_base_address_r    <= `REG_RESET;
    end else begin
      if (wr_ctrl) overlay_control_r <= ctrl_nxt;
      if (wr_col_lo) overlay_color_pair_low_r <= col_lo_nxt;
      if (wr_col_hi) overlay_color_pair_high_r <= col_hi_nxt;
      if (wr_pos) overlay_position_r <= pos_nxt;
      if (wr_base) overlay_base_address_r <= base_nxt;
    end
  end

  // Read mux; unmapped addresses return zero
  wire [31:0] rd_mux =
    (sel_dec == REG_CTRL)     ? overlay_control_r :
    (sel_dec == REG_COLOR_LO) ? overlay_color_pair_low_r :
    (sel_dec == REG_COLOR_HI) ? overlay_color_pair_high_r :
    (sel_dec == REG_POS)      ? overlay_position_r :
    (sel_dec == REG_BASE)     ? overlay_base_address_r : 32'h00000000;
  wire [31:0] rd_masked = {io_half_en[1] ? rd_mux[31:16] : 16'h0000,
                           io_half_en[0] ? rd_mux[15:0] : 16'h0000};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r  <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= io_rd;
      if (io_rd) rdata_r <= rd_masked;
    end
  end

  // Overlay select only moves at vertical blank so a frame never tears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_active_r <= 2'h0;
    end else if (vblank) begin
      sel_active_r <= overlay_control_r[`CTRL_SEL_LSB +: 2];
    end
  end

  // Derived display controls
  wire       menu_mode  = (sel_active_r == SEL_MENU);
  wire       posctl     = overlay_control_r[`CTRL_POSCTL_BIT];
  wire       autozoom   = overlay_control_r[`CTRL_AUTOZOOM_BIT] &&
                          !overlay_control_r[`CTRL_RSVD13_BIT] && !posctl;
  wire       two_bpp    = overlay_control_r[`CTRL_MENU_WIDTH_BIT];
  // Halving covers auto-zoom and plain position-control cases alike
  wire       halve_x    = menu_mode && low_res && !posctl;
  wire       dbl_width  = menu_mode && autozoom && !low_res;
  wire       transp_on  = menu_mode && two_bpp &&
                          overlay_control_r[`CTRL_TRANSP_BIT];
  wire       blink_on   = overlay_control_r[`CTRL_BLINK_BIT];
  wire       visible    = (sel_active_r != SEL_OFF) &&
                          (!blink_on || blink_phase);
  wire [11:0] x_calc;
  wire [11:0] y_calc;
  wire [15:0] color_calc;
  wire        transp_calc;

  overlay_pos_calc u_pos_x (
    .sign  (overlay_position_r[`POS_X_SIGN_BIT]),
    .mag   (overlay_position_r[`POS_X_MAG_MSB:0]),
    .halve (halve_x),
    .pos   (x_calc)
  );

  // Vertical never halves
  overlay_pos_calc u_pos_y (
    .sign  (overlay_position_r[`POS_Y_SIGN_BIT]),
    .mag   (overlay_position_r[`POS_Y_MAG_MSB:`POS_Y_MAG_LSB]),
    .halve (1'b0),
    .pos   (y_calc)
  );

  // Colour halves in 5-6-5 layout, two per register
  overlay_color_pick u_color (
    .colors      ({overlay_color_pair_high_r, overlay_color_pair_low_r}),
    .index       (pix_index),
    .menu_mode   (menu_mode),
    .transp_on   (transp_on),
    .color       (color_calc),
    .transparent (transp_calc)
  );

  // Output flops; colours bypass vblank, so a write shows the next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overlay_sel_r     <= 2'h0;
      visible_r         <= 1'b0;
      corner_r          <= 1'b0;
      two_bpp_r         <= 1'b0;
      x_zoom_r          <= 1'b0;
      y_zoom_r          <= 1'b0;
      width_double_r    <= 1'b0;
      pos_x_r           <= 12'h000;
      pos_y_r           <= 12'h000;
      image_base_r      <= 11'h000;
      pix_color_r       <= 16'h0000;
      pix_transparent_r <= 1'b0;
    end else begin
      overlay_sel_r     <= sel_active_r;
      visible_r         <= visible;
      corner_r          <= overlay_control_r[`CTRL_CORNER_BIT];
      two_bpp_r         <= two_bpp;
      x_zoom_r          <= overlay_control_r[`CTRL_XZOOM_BIT];
      y_zoom_r          <= overlay_control_r[`CTRL_YZOOM_BIT];
      width_double_r    <= dbl_width;
      pos_x_r           <= x_calc;
      pos_y_r           <= y_calc;
      image_base_r      <= overlay_base_address_r[`BASE_MSB:`BASE_LSB];
      pix_color_r       <= color_calc;
      pix_transparent_r <= transp_calc;
    end
  end

  assign io_rdata         = rdata_r;
  assign io_rvalid        = rvalid_r;
  assign overlay_sel      = overlay_sel_r;
  assign overlay_visible  = visible_r;
  assign reference_corner = corner_r;
  assign menu_two_bpp     = two_bpp_r;
  assign x_zoom           = x_zoom_r;
  assign y_zoom           = y_zoom_r;
  assign width_double     = width_double_r;
  assign pos_x            = pos_x_r;
  assign pos_y            = pos_y_r;
  assign image_base       = image_base_r;
  assign pix_color        = pix_color_r;
  assign pix_transparent  = pix_transparent_r;
endmodule
`default_nettype wire

// >>> tb/overlay_regs_bank_asserts.sv
// Port-level checks of the overlay register bank, bound to its top module.
// Assumes the register header on the include path and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_regs.svh"
module overlay_regs_bank_asserts
  import overlay_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [1:0]  io_half_en,
  input wire logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata,
  input wire logic        io_rvalid,
  input wire logic        vblank,
  input wire logic        low_res,
  input wire logic [1:0]  pix_index,
  input wire logic [1:0]  overlay_sel,
  input wire logic        reference_corner,
  input wire logic        menu_two_bpp,
  input wire logic        width_double,
  input wire logic [10:0] image_base,
  input wire logic        pix_transparent
);
  // Word decode, low two address bits dropped
  wire logic [15:0] waddr  = io_addr & 16'hfffc;
  wire logic        mapped = waddr == `OVL_CTRL_ADDR || waddr == `OVL_COLOR_LO_ADDR ||
                             waddr == `OVL_COLOR_HI_ADDR || waddr == `OVL_POS_ADDR ||
                             waddr == `OVL_BASE_ADDR;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RVALID_NEXT: assert property (io_rvalid == $past(io_rd))
    else $error("read valid not one cycle after read strobe");
  AST_UNMAPPED_ZERO: assert property (io_rd && !mapped |=> io_rdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  AST_CTRL_RSVD: assert property (
    io_rd && waddr == `OVL_CTRL_ADDR |=> (io_rdata & ~`CTRL_WMASK) == 32'h0)
    else $error("control reserved bits read nonzero");
  AST_POS_RSVD: assert property (
    io_rd && waddr == `OVL_POS_ADDR |=> (io_rdata & ~`POS_WMASK) == 32'h0)
    else $error("position unused bits read nonzero");
  AST_BASE_RSVD: assert property (
    io_rd && waddr == `OVL_BASE_ADDR |=> (io_rdata & ~`BASE_WMASK) == 32'h0)
    else $error("base address low or high bits read nonzero");
  // Select may only move at a vertical blank
  AST_SEL_AT_VBLANK: assert property (!vblank [*3] |-> $stable(overlay_sel))
    else $error("overlay select changed outside vertical blank");
  AST_TRANSP_IDX2: assert property (
    pix_transparent |-> $past(pix_index) == 2'h2 && menu_two_bpp)
    else $error("transparency outside colour index 2 of 64x64 menu");
  AST_WIDTH_HIRES: assert property (width_double |-> !$past(low_res))
    else $error("width doubled in low resolution");
  AST_BASE_LOAD: assert property (
    io_wr && io_half_en == 2'h3 && waddr == `OVL_BASE_ADDR ##1
    !(io_wr && waddr == `OVL_BASE_ADDR) |=> image_base == $past(io_wdata[20:10], 2))
    else $error("image base does not follow written field");
  AST_CORNER_LOAD: assert property (
    io_wr && io_half_en[0] && waddr == `OVL_CTRL_ADDR ##1
    !(io_wr && waddr == `OVL_CTRL_ADDR) |=> reference_corner == $past(io_wdata[5], 2))
    else $error("reference corner does not follow control write");

  // Main scenarios reached
  COV_UNMAPPED: cover property (io_rd && !mapped);
  COV_TRANSP: cover property (pix_transparent);
  COV_WIDTH: cover property (width_double);
  COV_SEL: cover property ($changed(overlay_sel));
endmodule
bind overlay_regs_bank overlay_regs_bank_asserts chk_i (.clk, .rst, .io_addr, .io_wr, .io_rd,
  .io_half_en, .io_wdata, .io_rdata, .io_rvalid, .vblank, .low_res, .pix_index, .overlay_sel,
  .reference_corner, .menu_two_bpp, .width_double, .image_base, .pix_transparent);
`default_nettype wire

// >>> tb/overlay_regs_bank_test.sv
// Self-checking bench for the overlay register bank: random I/O traffic plus display cases.
// Assumes the register header on the include path and the checker bound to the bank.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_regs.svh"
module overlay_regs_bank_test import overlay_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic        vblank = 1'b1, low_res = 1'b0, blink_phase = 1'b0;
  logic [15:0] io_addr = 16'h0;
  logic [1:0]  io_half_en = 2'h0, pix_index = 2'h0, h, hr;
  logic [31:0] io_wdata = 32'h0, io_rdata, rw;
  logic        io_rvalid, overlay_visible, reference_corner, menu_two_bpp, x_zoom, y_zoom;
  logic        width_double, pix_transparent;
  logic [1:0]  overlay_sel;
  logic [11:0] pos_x, pos_y;
  logic [10:0] image_base;
  logic [15:0] pix_color;
  int          miscompares = 0, total_checks = 0, seed = 9493, k;
  logic [31:0] shadow [6] = '{6{32'h0}};
  // Last entry is an unmapped hole with nothing writable
  logic [15:0] addrs [6] = '{`OVL_CTRL_ADDR, `OVL_COLOR_LO_ADDR, `OVL_COLOR_HI_ADDR,
                             `OVL_POS_ADDR, `OVL_BASE_ADDR, 16'hb7d0};
  logic [31:0] masks [6] = '{`CTRL_WMASK, 32'hffffffff, 32'hffffffff, `POS_WMASK,
                             `BASE_WMASK, 32'h0};

  overlay_regs_bank DUT (.clk, .rst, .io_addr, .io_wr, .io_rd, .io_half_en, .io_wdata,
    .io_rdata, .io_rvalid, .vblank, .low_res, .blink_phase, .pix_index, .overlay_sel,
    .overlay_visible, .reference_corner, .menu_two_bpp, .x_zoom, .y_zoom, .width_double,
    .pos_x, .pos_y, .image_base, .pix_color, .pix_transparent);

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #5;
  endtask

  // Write with an idle cycle after, so strobes never toggle twice in one step
  task automatic wr(input int n, input logic [1:0] he, input logic [31:0] d);
    logic [31:0] hm;
    hm = {{16{he[1]}}, {16{he[0]}}};
    io_addr = {addrs[n][15:2], d[1:0]};
    io_wr = 1'b1;
    io_half_en = he;
    io_wdata = d;
    tick;
    io_wr = 1'b0;
    tick;
    shadow[n] = ((shadow[n] & ~hm) | (d & hm)) & masks[n];
  endtask

  // Read valid stands for the cycle after the strobe only; read data holds until the next read
  task automatic rd(input int n, input logic [1:0] he);
    io_addr = addrs[n];
    io_rd = 1'b1;
    io_half_en = he;
    tick;
    io_rd = 1'b0;
    chk({31'h0, io_rvalid}, 32'h1);
    chk(io_rdata, shadow[n] & {{16{he[1]}}, {16{he[0]}}});
    tick;
  endtask

  function automatic logic [15:0] pick(input logic [1:0] j);
    logic [31:0] w;
    w = j[1] ? shadow[2] : shadow[1];
    return j[0] ? w[31:16] : w[15:0];
  endfunction

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test;
  end

  initial begin
    repeat (16) @(posedge clk);
    #5;
    rst = 1'b0;
    for (int i = 0; i < 6; i++) rd(i, 2'h3);
    // Random mixed-width traffic, low write address bits random too
    for (int i = 0; i < 60; i++) begin
      k = {$random(seed)} % 6;
      h = 2'($random(seed));
      hr = 2'($random(seed));
      if (h == 2'h0) h = 2'h3;
      if (hr == 2'h0) hr = 2'h3;
      vblank = 1'($random(seed));
      rw = $random(seed);
      if (k == 3) rw = rw & 32'h7fff7fff;
      if (k == 4) rw[10] = 1'b0;
      wr(k, h, rw);
      rd(k, hr);
    end
    vblank = 1'b1;
    wr(0, 2'h3, 32'h00000001);
    wr(1, 2'h3, 32'hf81f07e0);
    wr(2, 2'h3, 32'h001fabcd);
    // Cursor mode folds indices 2 and 3 onto colours 0 and 1
    for (int j = 0; j < 4; j++) begin
      pix_index = 2'(j);
      tick;
      chk({16'h0, pix_color}, {16'h0, pick({1'b0, pix_index[0]})});
    end
    wr(0, 2'h3, 32'h00000103);
    for (int j = 0; j < 4; j++) begin
      pix_index = 2'(j);
      tick;
      chk({16'h0, pix_color}, {16'h0, pick(pix_index)});
    end
    vblank = 1'b0;
    wr(2, 2'h2, 32'h12340000);
    chk({16'h0, pix_color}, 32'h1234);
    vblank = 1'b1;
    wr(0, 2'h3, 32'h00001103);
    pix_index = 2'h2;
    tick;
    chk({31'h0, pix_transparent}, 32'h1);
    wr(0, 2'h3, 32'h00001003);
    chk({31'h0, pix_transparent}, 32'h0);
    chk({31'h0, menu_two_bpp}, 32'h0);
    wr(3, 2'h3, 32'h000507ff);
    chk({20'h0, pos_x}, 32'h7ff);
    chk({20'h0, pos_y}, 32'h005);
    wr(3, 2'h1, 32'h00007923);
    chk({20'h0, pos_x}, 32'h123);
    low_res = 1'b1;
    tick;
    chk({20'h0, pos_x}, 32'h091);
    chk({20'h0, pos_y}, 32'h005);
    wr(0, 2'h3, 32'h00005003);
    chk({20'h0, pos_x}, 32'h123);
    wr(0, 2'h3, 32'h00000f03);
    chk({31'h0, width_double}, 32'h0);
    chk({30'h0, x_zoom, y_zoom}, 32'h3);
    chk({31'h0, menu_two_bpp}, 32'h1);
    low_res = 1'b0;
    tick;
    chk({31'h0, width_double}, 32'h1);
    wr(0, 2'h3, 32'h00004903);
    chk({30'h0, x_zoom, y_zoom}, 32'h0);
    chk({31'h0, width_double}, 32'h0);
    // Select held until a blank arrives
    vblank = 1'b0;
    wr(0, 2'h3, 32'h00000002);
    chk({30'h0, overlay_sel}, 32'h3);
    vblank = 1'b1;
    tick;
    tick;
    chk({30'h0, overlay_sel}, 32'h2);
    wr(0, 2'h3, 32'h00008001);
    tick;
    chk({31'h0, overlay_visible}, 32'h0);
    blink_phase = 1'b1;
    tick;
    tick;
    chk({31'h0, overlay_visible}, 32'h1);
    blink_phase = 1'b0;
    wr(0, 2'h3, 32'h00000001);
    tick;
    chk({31'h0, overlay_visible}, 32'h1);
    // Negative offsets only outside the menu
    wr(3, 2'h3, 32'h800587ff);
    chk({20'h0, pos_x}, 32'h801);
    chk({20'h0, pos_y}, 32'hffb);
    wr(4, 2'h3, 32'hffffffff);
    chk({21'h0, image_base}, 32'h7ff);
    rd(4, 2'h3);
    wr(0, 2'h1, 32'h00000021);
    chk({31'h0, reference_corner}, 32'h1);
    end_of_test;
  end
endmodule
`default_nettype wire
